// ### rtl/tlbpa_pkg.sv
// package: register map, entry layout, vectors
package tlbpa_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CFG       = 8'h00;
    localparam logic [7:0] OFS_TLB_INDEX = 8'h04;
    localparam logic [7:0] OFS_TLB_WORD0 = 8'h08;
    localparam logic [7:0] OFS_TLB_WORD1 = 8'h0C;
    localparam logic [7:0] OFS_PC1       = 8'h10;
    localparam logic [7:0] OFS_CHAN_ADDR = 8'h14;
    localparam logic [7:0] OFS_CHAN_CTRL = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h1C;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h24;
    localparam int         OFS_BITS      = 8;
    // widths
    localparam int ID_W   = 8;
    localparam int PGM_W  = 2;
    localparam int PERM_W = 6;
    localparam int OPT_W  = 3;
    localparam int VEC_W  = 8;
    localparam int OFF_W  = 10;
    localparam int VPN_W  = 22;
    // entry word 1 fields
    localparam int PERM_SR   = 0;
    localparam int PERM_SW   = 1;
    localparam int PERM_SE   = 2;
    localparam int PERM_UR   = 3;
    localparam int PERM_UW   = 4;
    localparam int PERM_UE   = 5;
    localparam int W1_VALID  = 6;
    localparam int W1_PGM_LO = 8;
    localparam int W1_RPN_LO = 10;
    // entry word 0 fields
    localparam int W0_TID_LO = 0;
    localparam int W0_TAG_LO = 10;
    // instruction bits carried on the qualifier outputs
    localparam int INSTR_OPT_LO = 16;
    // channel control register fields
    localparam int CC_KIND_LO = 0;
    localparam int CC_SUP     = 2;
    localparam int CC_OPT_LO  = 3;
    localparam int CC_VEC_LO  = 8;
    // interrupt status bits
    localparam int IRQ_N         = 4;
    localparam int IRQ_IPROT     = 0;
    localparam int IRQ_DPROT     = 1;
    localparam int IRQ_IMISS     = 2;
    localparam int IRQ_DMISS     = 3;
    // trap vectors
    localparam logic [7:0] VEC_U_IMISS = 8'h08;
    localparam logic [7:0] VEC_U_DMISS = 8'h09;
    localparam logic [7:0] VEC_S_IMISS = 8'h0A;
    localparam logic [7:0] VEC_S_DMISS = 8'h0B;
    localparam logic [7:0] VEC_IPROT   = 8'h0C;
    localparam logic [7:0] VEC_DPROT   = 8'h0D;
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // access kinds
    typedef enum logic [1:0] {KIND_FETCH, KIND_LOAD, KIND_STORE, KIND_ATOMIC_LOAD_THEN_STORE} tlbpa_kind_e;
    // ahb transfer type of a fresh single
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### rtl/tlbpa_store_if.sv
// interface: controller to entry store
`timescale 1ns/100ps
`default_nettype none
interface tlbpa_store_if #(parameter int IDX_W = 3);
    logic                             wr_en;     // commit one entry
    logic [IDX_W-1:0]                 wr_index;  // entry slot
    logic [31:0]                      wr_word0;  // tag and task id
    logic [31:0]                      wr_word1;  // valid, marks, perms, rpn
    logic [tlbpa_pkg::VPN_W-1:0]      lk_vpn;    // virtual page looked up
    logic [tlbpa_pkg::ID_W-1:0]       lk_pid;    // current process id
    logic                             lk_sup;    // supervisor lookup
    logic                             hit;       // exactly one match
    logic [tlbpa_pkg::VPN_W-1:0]      hit_rpn;   // matched real page
    logic [tlbpa_pkg::PGM_W-1:0]      hit_pgm;   // matched marker bits
    logic [tlbpa_pkg::PERM_W-1:0]     hit_perm;  // matched permissions
    modport store (input wr_en, wr_index, wr_word0, wr_word1, lk_vpn, lk_pid, lk_sup,
                   output hit, hit_rpn, hit_pgm, hit_perm);
    modport ctrl  (output wr_en, wr_index, wr_word0, wr_word1, lk_vpn, lk_pid, lk_sup,
                   input hit, hit_rpn, hit_pgm, hit_perm);
endinterface
`default_nettype wire

// ### rtl/tlbpa_entry_store.sv
// entry store: entries and registered lookup
`timescale 1ns/100ps
`default_nettype none
module tlbpa_entry_store #(
    parameter int ENTRIES = 8,
    parameter int IDX_W   = 3
) (
    // clock and reset
    input  wire logic    clk,
    input  wire logic    arst_n,
    // controller side
    tlbpa_store_if.store sp
);
    logic [31:0]        w0_mem [ENTRIES];  // tag and task id
    logic [31:0]        w1_mem [ENTRIES];  // valid, marks, perms, rpn
    logic [ENTRIES-1:0] match;             // per-entry match

    // per-entry compare: valid, tag, and task id rule
    for (genvar i = 0; i < ENTRIES; i++)
    begin : g_cmp
        logic [tlbpa_pkg::ID_W-1:0] task_identifier_field;
        logic                       id_ok;
        assign task_identifier_field   = w0_mem[i][tlbpa_pkg::W0_TID_LO +: tlbpa_pkg::ID_W];
        assign id_ok = sp.lk_sup ? (task_identifier_field == '0) : (task_identifier_field == sp.lk_pid);
        assign match[i] = w1_mem[i][tlbpa_pkg::W1_VALID] && id_ok
            && (w0_mem[i][tlbpa_pkg::W0_TAG_LO +: tlbpa_pkg::VPN_W] == sp.lk_vpn);
    end

    // entry writes; entries clear to invalid at reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < ENTRIES; i++)
            begin
                w0_mem[i] <= tlbpa_pkg::RST_WORD;
                w1_mem[i] <= tlbpa_pkg::RST_WORD;
            end
        end
        else if (sp.wr_en)
        begin
            w0_mem[sp.wr_index] <= sp.wr_word0;
            w1_mem[sp.wr_index] <= sp.wr_word1;  // valid cleared retires entry
        end
    end

    // registered lookup, hit on a single match
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sp.hit      <= 1'b0;
            sp.hit_rpn  <= '0;
            sp.hit_pgm  <= '0;
            sp.hit_perm <= '0;
        end
        else
        begin
            sp.hit      <= $onehot(match);
            sp.hit_rpn  <= '0;
            sp.hit_pgm  <= '0;
            sp.hit_perm <= '0;
            for (int i = 0; i < ENTRIES; i++)
            begin
                if (match[i])
                begin
                    sp.hit_rpn  <= w1_mem[i][tlbpa_pkg::W1_RPN_LO +: tlbpa_pkg::VPN_W];
                    sp.hit_pgm  <= w1_mem[i][tlbpa_pkg::W1_PGM_LO +: tlbpa_pkg::PGM_W];
                    sp.hit_perm <= w1_mem[i][tlbpa_pkg::PERM_SR +: tlbpa_pkg::PERM_W];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### rtl/tlbpa_top.sv
// top: translation check, traps, user outputs, registers
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - write with valid clear retires that entry
// - new process id hides unequal user entries
// - hidden entry matches again when id returns
// - user mode uses user read, write, execute
// - supervisor mode uses supervisor permission bits
// - atomic load-store needs both read and write
// - denial traps, separate data and fetch causes
// - fetch trap keeps pc1; data keeps channel regs
// - markers from entry, low without translation
// - user outputs valid exactly with the address
// - qualifiers carry instruction bits 18 to 16
// - qualifiers meaningful for data accesses only
// - vector fetches drive markers, qualifiers low
// - valid bit, task id match, supervisor id zero
// - protection vectors twelve fetch, thirteen data
module tlbpa_top #(
    parameter int ENTRIES = 8,
    parameter int IDX_W   = 3
) (
    // clock and reset
    input  wire logic                         SYS_CLK,
    input  wire logic                         ARST_N,
    // ahb-lite slave
    input  wire logic                         HSEL,
    input  wire logic [31:0]                  HADDR,
    input  wire logic [1:0]                   HTRANS,
    input  wire logic                         HWRITE,
    input  wire logic [2:0]                   HSIZE,
    input  wire logic [31:0]                  HWDATA,
    input  wire logic                         HREADY,
    output logic      [31:0]                  HRDATA,
    output logic                              HREADYOUT,
    output logic                              HRESP,
    // access request from the core
    input  wire logic                         ACC_REQ,
    input  wire logic [31:0]                  ACC_VADDR,
    input  wire logic [1:0]                   ACC_KIND,
    input  wire logic                         ACC_SUP,
    input  wire logic                         ACC_XLATE,
    input  wire logic                         ACC_VECTOR,
    input  wire logic [31:0]                  ACC_INSTR,
    input  wire logic                         ACC_DONE,
    output logic                              ACC_READY,
    // address phase toward memories
    output logic                              ADDR_VALID,
    output logic      [31:0]                  ADDR_OUT,
    output logic                              ADDR_SUP,
    output logic      [tlbpa_pkg::PGM_W-1:0]  PAGE_MARKER_OUTPUTS,
    output logic      [tlbpa_pkg::OPT_W-1:0]  ACCESS_QUALIFIER_OUTPUTS,
    // traps and interrupt
    output logic                              TRAP_PULSE,
    output logic      [tlbpa_pkg::VEC_W-1:0]  TRAP_VECTOR,
    output logic                              IRQ
);
    typedef enum {ST_IDLE, ST_LOOK, ST_DECIDE, ST_HOLD} tlbpa_state_e;

    tlbpa_store_if #(.IDX_W(IDX_W)) sif ();

    tlbpa_state_e            state_r;        // access sequencer
    logic [31:0]             vaddr_r;        // latched virtual address
    tlbpa_pkg::tlbpa_kind_e  kind_r;         // latched access kind
    logic                    sup_r;          // latched mode
    logic                    xlate_r;        // translation requested
    logic                    vector_r;       // vector fetch
    logic [2:0]              opt_r;          // latched instruction bits
    logic [tlbpa_pkg::ID_W-1:0] pid_r;       // process identifier
    logic [IDX_W-1:0]        index_r;        // entry slot for writes
    logic [31:0]             word0_r;        // staged entry word 0
    logic [31:0]             pc1_r;          // faulting fetch address
    logic [31:0]             chan_addr_r;    // faulting data address
    logic [31:0]             chan_ctrl_r;    // faulting data details
    logic [tlbpa_pkg::IRQ_N-1:0] stat_r;     // sticky events
    logic [tlbpa_pkg::IRQ_N-1:0] en_r;       // event enables
    logic [tlbpa_pkg::IRQ_N-1:0] ev_set;     // events this cycle
    logic [tlbpa_pkg::IRQ_N-1:0] ev_clr;     // software clears
    logic                    wr_pend_r;      // ahb write data phase due
    logic [7:0]              wr_ofs_r;       // ahb write offset
    logic                    ahb_go;         // valid address phase
    logic                    is_fetch;       // latched kind is a fetch
    logic                    trap;           // decide cycle traps
    logic [7:0]              trap_vec;       // vector of that trap

    // read, write or execute right for the access mode and kind
    function automatic logic perm_ok(input logic [5:0] p, input logic s,
                                     input tlbpa_pkg::tlbpa_kind_e k);
        logic r;
        logic w;
        logic x;
        r = s ? p[tlbpa_pkg::PERM_SR] : p[tlbpa_pkg::PERM_UR];
        w = s ? p[tlbpa_pkg::PERM_SW] : p[tlbpa_pkg::PERM_UW];
        x = s ? p[tlbpa_pkg::PERM_SE] : p[tlbpa_pkg::PERM_UE];
        unique case (k)
            tlbpa_pkg::KIND_FETCH:   perm_ok = x;
            tlbpa_pkg::KIND_LOAD:    perm_ok = r;
            tlbpa_pkg::KIND_STORE:   perm_ok = w;
            tlbpa_pkg::KIND_ATOMIC_LOAD_THEN_STORE: perm_ok = r & w;  // needs both read and write
        endcase
    endfunction

    tlbpa_entry_store #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_store (
        .clk    (SYS_CLK),
        .arst_n (ARST_N),
        .sp     (sif.store)
    );

    // lookup port follows the latched request
    assign sif.lk_vpn   = vaddr_r[31 -: tlbpa_pkg::VPN_W];
    assign sif.lk_pid   = pid_r;
    assign sif.lk_sup   = sup_r;
    assign sif.wr_index = index_r;
    assign sif.wr_word0 = word0_r;
    assign sif.wr_word1 = HWDATA;
    assign sif.wr_en    = wr_pend_r && (wr_ofs_r == tlbpa_pkg::OFS_TLB_WORD1);

    assign ahb_go   = HSEL && HREADY && (HTRANS == tlbpa_pkg::HTRANS_NONSEQ);
    assign is_fetch = (kind_r == tlbpa_pkg::KIND_FETCH);

    // trap decision on the lookup result
    always_comb
    begin
        trap     = 1'b0;
        trap_vec = '0;
        if (xlate_r && !sif.hit)
        begin
            trap     = 1'b1;  // miss path, no protection
            if (sup_r)
                trap_vec = is_fetch ? tlbpa_pkg::VEC_S_IMISS : tlbpa_pkg::VEC_S_DMISS;
            else
                trap_vec = is_fetch ? tlbpa_pkg::VEC_U_IMISS : tlbpa_pkg::VEC_U_DMISS;
        end
        else if (xlate_r && !perm_ok(sif.hit_perm, sup_r, kind_r))
        begin
            trap     = 1'b1;
            trap_vec = is_fetch ? tlbpa_pkg::VEC_IPROT : tlbpa_pkg::VEC_DPROT;
        end
    end

    // access sequencer and latched request
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_r   <= ST_IDLE;
            vaddr_r   <= '0;
            kind_r    <= tlbpa_pkg::KIND_FETCH;
            sup_r     <= 1'b0;
            xlate_r   <= 1'b0;
            vector_r  <= 1'b0;
            opt_r     <= '0;
            ACC_READY <= 1'b1;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    if (ACC_REQ)
                    begin
                        state_r   <= ST_LOOK;
                        vaddr_r   <= ACC_VADDR;
                        kind_r    <= tlbpa_pkg::tlbpa_kind_e'(ACC_KIND);
                        sup_r     <= ACC_SUP;
                        xlate_r   <= ACC_XLATE;
                        vector_r  <= ACC_VECTOR;
                        opt_r     <= ACC_INSTR[tlbpa_pkg::INSTR_OPT_LO +: tlbpa_pkg::OPT_W];
                        ACC_READY <= 1'b0;
                    end
                end
                ST_LOOK:
                    state_r <= ST_DECIDE;  // store registers its result
                ST_DECIDE:
                begin
                    state_r   <= trap ? ST_IDLE : ST_HOLD;
                    ACC_READY <= trap;
                end
                ST_HOLD:
                begin
                    if (ACC_DONE)
                    begin
                        state_r   <= ST_IDLE;
                        ACC_READY <= 1'b1;
                    end
                end
            endcase
        end
    end

    // address and user outputs launched together; valid, markers, qualifiers dropped together
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ADDR_VALID               <= 1'b0;
            ADDR_OUT                 <= '0;
            ADDR_SUP                 <= 1'b0;
            PAGE_MARKER_OUTPUTS      <= '0;
            ACCESS_QUALIFIER_OUTPUTS <= '0;
        end
        else if (state_r == ST_DECIDE && !trap)
        begin
            ADDR_VALID <= 1'b1;
            ADDR_SUP   <= sup_r;
            ADDR_OUT   <= xlate_r ? {sif.hit_rpn, vaddr_r[tlbpa_pkg::OFF_W-1:0]} : vaddr_r;
            // markers from the entry; low untranslated or on vectors
            PAGE_MARKER_OUTPUTS <= (xlate_r && !vector_r) ? sif.hit_pgm : '0;
            // qualifiers only for data accesses, low on vectors
            ACCESS_QUALIFIER_OUTPUTS <= (is_fetch || vector_r) ? '0 : opt_r;
        end
        else if (state_r == ST_HOLD && ACC_DONE)
        begin
            ADDR_VALID               <= 1'b0;
            PAGE_MARKER_OUTPUTS      <= '0;
            ACCESS_QUALIFIER_OUTPUTS <= '0;
        end
    end

    // trap pulse and fault capture registers
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            TRAP_PULSE  <= 1'b0;
            TRAP_VECTOR <= '0;
            pc1_r       <= tlbpa_pkg::RST_WORD;
            chan_addr_r <= tlbpa_pkg::RST_WORD;
            chan_ctrl_r <= tlbpa_pkg::RST_WORD;
        end
        else
        begin
            TRAP_PULSE <= (state_r == ST_DECIDE) && trap;
            if (state_r == ST_DECIDE && trap)
            begin
                TRAP_VECTOR <= trap_vec;
                if (is_fetch)
                    pc1_r <= vaddr_r;
                else
                begin
                    chan_addr_r <= vaddr_r;
                    chan_ctrl_r <= '0;
                    chan_ctrl_r[tlbpa_pkg::CC_KIND_LO +: 2] <= kind_r;
                    chan_ctrl_r[tlbpa_pkg::CC_SUP] <= sup_r;
                    chan_ctrl_r[tlbpa_pkg::CC_OPT_LO +: tlbpa_pkg::OPT_W] <= opt_r;
                    chan_ctrl_r[tlbpa_pkg::CC_VEC_LO +: tlbpa_pkg::VEC_W] <= trap_vec;
                end
            end
        end
    end

    // event set and software clear vectors
    always_comb
    begin
        ev_set = '0;
        if (state_r == ST_DECIDE && trap)
        begin
            unique case (trap_vec)
                tlbpa_pkg::VEC_IPROT:   ev_set[tlbpa_pkg::IRQ_IPROT] = 1'b1;
                tlbpa_pkg::VEC_DPROT:   ev_set[tlbpa_pkg::IRQ_DPROT] = 1'b1;
                tlbpa_pkg::VEC_U_IMISS,
                tlbpa_pkg::VEC_S_IMISS: ev_set[tlbpa_pkg::IRQ_IMISS] = 1'b1;
                default:                ev_set[tlbpa_pkg::IRQ_DMISS] = 1'b1;
            endcase
        end
        ev_clr = '0;
        if (wr_pend_r && wr_ofs_r == tlbpa_pkg::OFS_IRQ_CLR)
            ev_clr = HWDATA[tlbpa_pkg::IRQ_N-1:0];
    end

    // sticky status, set beats clear, and level interrupt
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            stat_r <= '0;
            IRQ    <= 1'b0;
        end
        else
        begin
            stat_r <= (stat_r & ~ev_clr) | ev_set;
            IRQ    <= |(((stat_r & ~ev_clr) | ev_set) & en_r);
        end
    end

    // ahb address phase: latch writes, register read data
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            wr_pend_r <= 1'b0;
            wr_ofs_r  <= '0;
            HRDATA    <= '0;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
        else
        begin
            HREADYOUT <= 1'b1;  // zero wait states
            HRESP     <= 1'b0;  // always okay
            wr_pend_r <= ahb_go && HWRITE;
            wr_ofs_r  <= HADDR[tlbpa_pkg::OFS_BITS-1:0];
            if (ahb_go && !HWRITE)
            begin
                unique case (HADDR[tlbpa_pkg::OFS_BITS-1:0])
                    tlbpa_pkg::OFS_CFG:       HRDATA <= 32'(pid_r);
                    tlbpa_pkg::OFS_TLB_INDEX: HRDATA <= 32'(index_r);
                    tlbpa_pkg::OFS_TLB_WORD0: HRDATA <= word0_r;
                    tlbpa_pkg::OFS_PC1:       HRDATA <= pc1_r;
                    tlbpa_pkg::OFS_CHAN_ADDR: HRDATA <= chan_addr_r;
                    tlbpa_pkg::OFS_CHAN_CTRL: HRDATA <= chan_ctrl_r;
                    tlbpa_pkg::OFS_IRQ_STAT:  HRDATA <= 32'(stat_r);
                    tlbpa_pkg::OFS_IRQ_EN:    HRDATA <= 32'(en_r);
                    default:                  HRDATA <= '0;  // unmapped or write-only
                endcase
            end
        end
    end

    // ahb data phase: software-written registers
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pid_r   <= '0;
            index_r <= '0;
            word0_r <= tlbpa_pkg::RST_WORD;
            en_r    <= '0;
        end
        else if (wr_pend_r)
        begin
            unique case (wr_ofs_r)
                tlbpa_pkg::OFS_CFG:       pid_r   <= HWDATA[tlbpa_pkg::ID_W-1:0];
                tlbpa_pkg::OFS_TLB_INDEX: index_r <= HWDATA[IDX_W-1:0];
                tlbpa_pkg::OFS_TLB_WORD0: word0_r <= HWDATA;
                tlbpa_pkg::OFS_IRQ_EN:    en_r    <= HWDATA[tlbpa_pkg::IRQ_N-1:0];
                default:                  ;  // other offsets have no stored bits
            endcase
        end
    end
endmodule
`default_nettype wire

// ### dv/tlbpa_asserts.sv
// checker: access answer and address phase
`timescale 1ns/100ps
`default_nettype none
module tlbpa_asserts (
    // clock, reset, access request
    input wire logic        SYS_CLK,
    input wire logic        ARST_N,
    input wire logic        ACC_REQ,
    input wire logic        ACC_READY,
    input wire logic        ACC_XLATE,
    input wire logic        ACC_VECTOR,
    input wire logic        ACC_DONE,
    input wire logic [1:0]  ACC_KIND,
    input wire logic [31:0] ACC_INSTR,
    // address phase and traps
    input wire logic        ADDR_VALID,
    input wire logic [31:0] ADDR_OUT,
    input wire logic [1:0]  PAGE_MARKER_OUTPUTS,
    input wire logic [2:0]  ACCESS_QUALIFIER_OUTPUTS,
    input wire logic        TRAP_PULSE,
    input wire logic [7:0]  TRAP_VECTOR
);
    logic       take; // accepted request
    logic [2:0] opt;  // qualifier source
    assign take = ACC_REQ && ACC_READY;
    assign opt = ACC_INSTR[18:16];
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    answer_once_a: assert property (take |-> ##3 (ADDR_VALID != TRAP_PULSE))
        else $error("no single answer");
    trap_pulse_a: assert property (TRAP_PULSE |=> !TRAP_PULSE)
        else $error("trap too long");
    trap_vec_a: assert property (TRAP_PULSE |-> TRAP_VECTOR inside {[8'h08:8'h0D]})
        else $error("bad trap vector");
    qual_src_a: assert property (take && ACC_KIND != 2'h0 && !ACC_VECTOR |->
        ##3 (!ADDR_VALID || ACCESS_QUALIFIER_OUTPUTS == $past(opt, 3)))
        else $error("bad qualifiers");
    no_xlate_a: assert property (take && !ACC_XLATE |->
        ##3 (ADDR_VALID && PAGE_MARKER_OUTPUTS == 2'h0))
        else $error("bad untranslated access");
    vec_low_a: assert property (take && ACC_VECTOR |->
        ##3 (PAGE_MARKER_OUTPUTS == 2'h0 && ACCESS_QUALIFIER_OUTPUTS == 3'h0))
        else $error("vector outputs not low");
    addr_hold_a: assert property (ADDR_VALID && !ACC_DONE |=> ADDR_VALID &&
        $stable(ADDR_OUT) && $stable(PAGE_MARKER_OUTPUTS) && $stable(ACCESS_QUALIFIER_OUTPUTS))
        else $error("address phase unstable");
    addr_drop_a: assert property (ADDR_VALID && ACC_DONE |=> !ADDR_VALID &&
        PAGE_MARKER_OUTPUTS == 2'h0 && ACCESS_QUALIFIER_OUTPUTS == 3'h0)
        else $error("address phase too long");
endmodule
bind tlbpa_top tlbpa_asserts tlbpa_asserts_i (.*);
`default_nettype wire

// ### dv/tlbpa_mem_model.sv
// channel memory model: ends held address phases
`timescale 1ns/100ps
`default_nettype none
module tlbpa_mem_model (
    // clock, reset, address phase, wait
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire logic       addr_valid,
    input wire logic [3:0] wait_cyc,
    // completion toward the core
    output logic           acc_done
);
    logic [3:0] cnt_r; // cycles held
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= 4'h0;
            acc_done <= 1'b0;
        end
        else
        begin
            cnt_r <= (addr_valid && !acc_done) ? cnt_r + 4'h1 : 4'h0;
            acc_done <= addr_valid && !acc_done && cnt_r >= wait_cyc;
        end
    end
endmodule
`default_nettype wire

// ### dv/tlbpa_top_tb_top.sv
// testbench: random accesses, traps, interrupt, registers
`timescale 1ns/100ps
`default_nettype none
module tlbpa_top_tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, req = 1'b0, av_d = 1'b0;
    logic        hwrite, sup, xlate, vect, asup, hresp;
    logic [1:0]  htrans, kind, entry_marker_bits;
    logic [31:0] haddr, hwdata, vaddr, instr, hrdata, aout;
    logic [3:0]  wcyc = 4'h0;
    logic [2:0]  qual;
    logic [7:0]  tvec;
    logic        hrdy, ready, done, avalid, trap, irq;
    logic [45:0] exp_q[$]; // expected answers
    int          n_mismatch, n_compared, cyc;
    // 40 MHz clock
    initial forever #12.5 clk = ~clk;
    tlbpa_top tlbpa_top_i (.SYS_CLK(clk), .ARST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .ACC_REQ(req), .ACC_VADDR(vaddr),
        .ACC_KIND(kind), .ACC_SUP(sup), .ACC_XLATE(xlate), .ACC_VECTOR(vect),
        .ACC_INSTR(instr), .ACC_DONE(done), .ACC_READY(ready), .ADDR_VALID(avalid),
        .ADDR_OUT(aout), .ADDR_SUP(asup), .PAGE_MARKER_OUTPUTS(entry_marker_bits), .TRAP_PULSE(trap),
        .ACCESS_QUALIFIER_OUTPUTS(qual), .TRAP_VECTOR(tvec), .IRQ(irq));
    tlbpa_mem_model tlbpa_mem_model_i (.sys_clk(clk), .arst_n(rst_n), .addr_valid(avalid),
        .wait_cyc(wcyc), .acc_done(done));
    // compare and count
    task automatic chk(input logic [45:0] got, input logic [45:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one ahb-lite word transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= tlbpa_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    // one access, then back to idle
    task automatic acc(input logic [31:0] va, input logic [1:0] k, input logic s, x, v,
                       input logic [31:0] ins);
        req <= 1'b1;
        vaddr <= va;
        kind <= k;
        sup <= s;
        xlate <= x;
        vect <= v;
        instr <= ins;
        do @(posedge clk); while (ready !== 1'b1);
        req <= 1'b0;
        do @(posedge clk); while (ready !== 1'b1);
    endtask
    // expected permission
    function automatic logic pok(input logic [5:0] p, input logic [1:0] k, input logic s);
        logic [2:0] b;
        b = s ? p[2:0] : p[5:3];
        return k == 2'h0 ? b[2] : (b[0] | !k[0]) & (b[1] | !k[1]);
    endfunction
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watcher: each answer takes the oldest note
    always @(posedge clk)
    begin
        if (trap === 1'b1 || (avalid === 1'b1 && !av_d))
            chk(trap === 1'b1 ? {1'b1, tvec, 37'h0} : {8'h0, asup, aout, entry_marker_bits, qual},
                exp_q.pop_front());
        av_d <= avalid;
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial
    begin
        logic [31:0] r, r2, va, ins, q;
        logic [7:0]  task_identifier_field, process_identifier_field;
        logic [2:0]  qv;
        logic [1:0]  k;
        logic        hit, x, v, s;
        logic [45:0] e;
        void'($urandom(32'hB19DF90D));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 80; i++)
        begin
            r = $urandom;
            r2 = $urandom;
            va = $urandom;
            ins = $urandom;
            task_identifier_field = r[7] ? 8'h05 : 8'h00;
            process_identifier_field = r[8] ? 8'h05 : 8'h06;
            x = r[15] | r[14];
            v = r[15:14] == 2'h1;
            k = v ? 2'h0 : r[12:11];
            s = r[13];
            hit = r[6] && (s ? task_identifier_field == 8'h00 : task_identifier_field == process_identifier_field);
            qv = k == 2'h0 ? 3'h0 : ins[18:16];
            if (!x) e = {8'h0, s, va, 2'h0, qv};
            else if (!hit) e = {5'h10, 2'h2, s, k != 2'h0, 37'h0};
            else if (!pok(r[5:0], k, s))
                e = {1'b1, k == 2'h0 ? tlbpa_pkg::VEC_IPROT : tlbpa_pkg::VEC_DPROT, 37'h0};
            else e = {8'h0, s, r2[21:0], va[9:0], v ? 2'h0 : r[10:9], qv};
            wcyc <= r2[25:22];
            bus(1'b1, tlbpa_pkg::OFS_IRQ_EN, {28'h0, {4{r[31]}}}, q);
            bus(1'b1, tlbpa_pkg::OFS_CFG, {24'h0, process_identifier_field}, q);
            bus(1'b1, tlbpa_pkg::OFS_TLB_INDEX, 32'h0, q);
            bus(1'b1, tlbpa_pkg::OFS_TLB_WORD0, {va[31:10], 2'h0, task_identifier_field}, q);
            bus(1'b1, tlbpa_pkg::OFS_TLB_WORD1, {r2[21:0], r[10:9], 1'b0, r[6], r[5:0]}, q);
            exp_q.push_back(e);
            acc(va, k, s, x, v, ins);
            bus(1'b0, k == 2'h0 ? tlbpa_pkg::OFS_PC1 : tlbpa_pkg::OFS_CHAN_ADDR, 32'h0, q);
            if (e[45]) chk(46'(q), 46'(va));
            chk(46'(irq), 46'(e[45] & r[31]));
            bus(1'b1, tlbpa_pkg::OFS_IRQ_CLR, 32'hF, q);
            $display("test %0d done", i);
        end
        bus(1'b0, 8'h80, 32'h0, q);
        chk({13'h0, hresp, q}, 46'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
